// [hw/bdm_pkg.sv]
package bdm_pkg;

    // ------------------------------------------------------------
    // variants of the general-purpose file
    // ------------------------------------------------------------
    localparam logic [1:0] VARIANT_80 = 2'h0;
    localparam logic [1:0] VARIANT_96 = 2'h1;
    localparam logic [1:0] VARIANT_128 = 2'h2;

    // ------------------------------------------------------------
    // register offsets within a bank
    // ------------------------------------------------------------
    localparam logic [6:0] OFF_INDIRECT_DATA_PORT = 7'h00;
    localparam logic [6:0] OFF_TIMER_COUNT = 7'h01;
    localparam logic [6:0] OFF_PROGRAM_COUNTER_LOW = 7'h02;
    localparam logic [6:0] OFF_CORE_FLAGS = 7'h03;
    localparam logic [6:0] OFF_INDIRECT_POINTER = 7'h04;
    localparam logic [6:0] OFF_PORT_A_PINS = 7'h05;
    localparam logic [6:0] OFF_PORT_B_PINS = 7'h06;
    localparam logic [6:0] OFF_PROGRAM_COUNTER_HIGH_LATCH = 7'h0A;
    localparam logic [6:0] OFF_INTERRUPT_CONTROL = 7'h0B;
    localparam logic [6:0] OFF_PERIPHERAL_FLAGS = 7'h0C;
    localparam logic [6:0] OFF_COMPARATOR_CONTROL = 7'h1F;
    localparam logic [6:0] OFF_CORE_OPTIONS = 7'h01;
    localparam logic [6:0] SFR_SPAN = 7'h20;

    // ------------------------------------------------------------
    // general-purpose ranges, full 8-bit data addresses
    // ------------------------------------------------------------
    localparam logic [7:0] GPR0_BASE = 8'h20;
    localparam logic [7:0] GPR0_TOP_80 = 8'h6F;
    localparam logic [7:0] GPR0_TOP = 8'h7F;
    localparam logic [7:0] GPR1_BASE = 8'hA0;
    localparam logic [7:0] GPR1_TOP = 8'hBF;
    localparam logic [7:0] GPR1_INDEX = 8'h60;
    localparam logic [7:0] COMMON_BASE = 8'hF0;
    localparam logic [7:0] COMMON_INDEX = 8'h50;
    localparam int RAM_DEPTH = 128;

    // ------------------------------------------------------------
    // field positions and masks
    // ------------------------------------------------------------
    localparam int BANK_SELECT_POS = 5;
    localparam logic [7:0] PORT_A_MASK = 8'h1F;
    localparam logic [7:0] PC_HIGH_LATCH_MASK = 8'h1F;
    localparam logic [7:0] PERIPHERAL_FLAGS_MASK = 8'h40;
    localparam logic [7:0] COMPARATOR_MASK = 8'hCF;

    // ------------------------------------------------------------
    // power-on values
    // ------------------------------------------------------------
    localparam logic [7:0] POR_TIMER_COUNT = 8'h00;
    localparam logic [7:0] POR_PROGRAM_COUNTER_LOW = 8'h00;
    localparam logic [7:0] POR_CORE_FLAGS = 8'h18;
    localparam logic [7:0] POR_INDIRECT_POINTER = 8'h00;
    localparam logic [7:0] POR_PORT_A = 8'h00;
    localparam logic [7:0] POR_PORT_B = 8'h00;
    localparam logic [7:0] POR_PC_HIGH_LATCH = 8'h00;
    localparam logic [7:0] POR_INTERRUPT_CONTROL = 8'h00;
    localparam logic [7:0] POR_PERIPHERAL_FLAGS = 8'h00;
    localparam logic [7:0] POR_COMPARATOR = 8'h00;
    localparam logic [7:0] POR_CORE_OPTIONS = 8'hFF;

    // ------------------------------------------------------------
    // other-reset values: keep-mask selects bits left unchanged
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PROGRAM_COUNTER_LOW = 8'h00;
    localparam logic [7:0] KEEP_CORE_FLAGS = 8'h1F;
    localparam logic [7:0] KEEP_PORT_A = 8'h10;
    localparam logic [7:0] RST_PC_HIGH_LATCH = 8'h00;
    localparam logic [7:0] KEEP_INTERRUPT_CONTROL = 8'h01;
    localparam logic [7:0] RST_PERIPHERAL_FLAGS = 8'h00;
    localparam logic [7:0] RST_COMPARATOR = 8'h00;
    localparam logic [7:0] RST_CORE_OPTIONS = 8'hFF;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic indirect;
        logic [6:0] addr;
        logic [7:0] wdata;
    } bdm_req_s;

    typedef struct packed {
        logic [7:0] timer_count;
        logic [7:0] program_counter_low;
        logic [7:0] core_flags;
        logic [7:0] indirect_pointer;
        logic [7:0] port_a_pins;
        logic [7:0] port_b_pins;
        logic [7:0] program_counter_high_latch;
        logic [7:0] interrupt_control;
        logic [7:0] peripheral_flags;
        logic [7:0] comparator_control;
        logic [7:0] core_options;
    } bdm_regs_s;

endpackage

// [hw/bdm_decoder.sv]
`timescale 1ns/1ps
module bdm_decoder #(
    parameter logic [1:0] VARIANT = bdm_pkg::VARIANT_128
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic other_reset,
    input wire bdm_pkg::bdm_req_s req,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output bdm_pkg::bdm_regs_s regs
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // returns {hit, index} for the general file
    // variant gates the upper rows and the bank 1 block
    function automatic logic [7:0] ram_map(input logic [7:0] a);
        logic hit;
        logic [6:0] idx;
        hit = 1'b0;
        idx = 7'h00;
        if (a >= bdm_pkg::GPR0_BASE && a <= bdm_pkg::GPR0_TOP) begin
            hit = (VARIANT != bdm_pkg::VARIANT_80) ||
                  (a <= bdm_pkg::GPR0_TOP_80);
            idx = 7'(a - bdm_pkg::GPR0_BASE);
        end else if (a >= bdm_pkg::GPR1_BASE && a <= bdm_pkg::GPR1_TOP) begin
            hit = (VARIANT == bdm_pkg::VARIANT_128);
            idx = 7'(a - bdm_pkg::GPR1_BASE + bdm_pkg::GPR1_INDEX);
        end else if (a >= bdm_pkg::COMMON_BASE) begin
            hit = (VARIANT != bdm_pkg::VARIANT_80);
            idx = 7'(a - bdm_pkg::COMMON_BASE + bdm_pkg::COMMON_INDEX);
        end
        return {hit, idx};
    endfunction

    // ------------------------------------------------------------
    // storage and effective address
    // ------------------------------------------------------------
    bdm_pkg::bdm_regs_s r;
    logic [7:0] ram [0:bdm_pkg::RAM_DEPTH-1];
    // reserved upper flag bits are kept but never steer the decode
    wire bank = r.core_flags[bdm_pkg::BANK_SELECT_POS];
    // a pointer to 00h or 80h lands on the port itself: reads zero
    // port offset redirects
    wire use_ptr = req.indirect ||
                   (req.addr == bdm_pkg::OFF_INDIRECT_DATA_PORT);
    wire [7:0] eff = use_ptr ? r.indirect_pointer : {bank, req.addr};
    wire eff_bank = eff[7];
    wire [6:0] off = eff[6:0];
    wire [7:0] map = ram_map(eff);
    wire ram_hit = map[7];
    wire [6:0] ram_idx = map[6:0];
    // low 32 offsets are special registers
    wire is_sfr = off < bdm_pkg::SFR_SPAN;
    // other reset outranks a write landing in the same cycle
    wire wr = clk_en && req.wr && !other_reset;
    wire rd = clk_en && req.rd;

    // ------------------------------------------------------------
    // special register select
    // ------------------------------------------------------------
    // timer in bank 0 only, options in bank 1 only
    wire sel_tmr = is_sfr && !eff_bank && off == bdm_pkg::OFF_TIMER_COUNT;
    wire sel_opt = is_sfr && eff_bank && off == bdm_pkg::OFF_CORE_OPTIONS;
    wire sel_pc_lo = is_sfr && off == bdm_pkg::OFF_PROGRAM_COUNTER_LOW;
    wire sel_flg = is_sfr && off == bdm_pkg::OFF_CORE_FLAGS;
    wire sel_ptr = is_sfr && off == bdm_pkg::OFF_INDIRECT_POINTER;
    wire sel_pta = is_sfr && !eff_bank && off == bdm_pkg::OFF_PORT_A_PINS;
    wire sel_ptb = is_sfr && !eff_bank && off == bdm_pkg::OFF_PORT_B_PINS;
    wire sel_lat = is_sfr && off == bdm_pkg::OFF_PROGRAM_COUNTER_HIGH_LATCH;
    wire sel_int = is_sfr && off == bdm_pkg::OFF_INTERRUPT_CONTROL;
    wire sel_pir = is_sfr && !eff_bank &&
                   off == bdm_pkg::OFF_PERIPHERAL_FLAGS;
    wire sel_cmp = is_sfr && !eff_bank &&
                   off == bdm_pkg::OFF_COMPARATOR_CONTROL;

    // bank 1 port mirrors belong to other blocks and read zero
    // anything unselected reads zero
    wire [7:0] sfr_rd =
        ({8{sel_tmr}} & r.timer_count) |
        ({8{sel_opt}} & r.core_options) |
        ({8{sel_pc_lo}} & r.program_counter_low) |
        ({8{sel_flg}} & r.core_flags) |
        ({8{sel_ptr}} & r.indirect_pointer) |
        ({8{sel_pta}} & r.port_a_pins) |
        ({8{sel_ptb}} & r.port_b_pins) |
        ({8{sel_lat}} & r.program_counter_high_latch) |
        ({8{sel_int}} & r.interrupt_control) |
        ({8{sel_pir}} & r.peripheral_flags) |
        ({8{sel_cmp}} & r.comparator_control);
    wire [7:0] next_rd_data = is_sfr ? sfr_rd :
                              (ram_hit ? ram[ram_idx] : 8'h00);

    // ------------------------------------------------------------
    // other-reset values, unchanged bits carried over
    // ------------------------------------------------------------
    // other reset keeps marked bits
    bdm_pkg::bdm_regs_s rst_val;
    assign rst_val = '{
        timer_count: r.timer_count,
        program_counter_low: bdm_pkg::RST_PROGRAM_COUNTER_LOW,
        core_flags: r.core_flags & bdm_pkg::KEEP_CORE_FLAGS,
        indirect_pointer: r.indirect_pointer,
        port_a_pins: r.port_a_pins & bdm_pkg::KEEP_PORT_A,
        port_b_pins: r.port_b_pins,
        program_counter_high_latch: bdm_pkg::RST_PC_HIGH_LATCH,
        interrupt_control: r.interrupt_control &
                           bdm_pkg::KEEP_INTERRUPT_CONTROL,
        peripheral_flags: bdm_pkg::RST_PERIPHERAL_FLAGS,
        comparator_control: bdm_pkg::RST_COMPARATOR,
        core_options: bdm_pkg::RST_CORE_OPTIONS
    };

    // ------------------------------------------------------------
    // write data per register, unimplemented bits forced low
    // ------------------------------------------------------------
    // narrow registers store only implemented bits
    wire [7:0] wd = req.wdata;
    bdm_pkg::bdm_regs_s next_r;
    // timer counting lives in the timer block; only core writes here
    assign next_r = '{
        timer_count: (wr && sel_tmr) ? wd : r.timer_count,
        program_counter_low: (wr && sel_pc_lo) ? wd : r.program_counter_low,
        core_flags: (wr && sel_flg) ? wd : r.core_flags,
        indirect_pointer: (wr && sel_ptr) ? wd : r.indirect_pointer,
        port_a_pins: (wr && sel_pta) ? (wd & bdm_pkg::PORT_A_MASK) :
                     r.port_a_pins,
        port_b_pins: (wr && sel_ptb) ? wd : r.port_b_pins,
        program_counter_high_latch: (wr && sel_lat) ?
                     (wd & bdm_pkg::PC_HIGH_LATCH_MASK) :
                     r.program_counter_high_latch,
        interrupt_control: (wr && sel_int) ? wd : r.interrupt_control,
        peripheral_flags: (wr && sel_pir) ?
                     (wd & bdm_pkg::PERIPHERAL_FLAGS_MASK) :
                     r.peripheral_flags,
        comparator_control: (wr && sel_cmp) ?
                     (wd & bdm_pkg::COMPARATOR_MASK) :
                     r.comparator_control,
        core_options: (wr && sel_opt) ? wd : r.core_options
    };

    // ------------------------------------------------------------
    // special registers
    // ------------------------------------------------------------
    // clock enable low freezes every register below
    // registers hold until written or reset
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '{
                timer_count: bdm_pkg::POR_TIMER_COUNT,
                program_counter_low: bdm_pkg::POR_PROGRAM_COUNTER_LOW,
                core_flags: bdm_pkg::POR_CORE_FLAGS,
                indirect_pointer: bdm_pkg::POR_INDIRECT_POINTER,
                port_a_pins: bdm_pkg::POR_PORT_A,
                port_b_pins: bdm_pkg::POR_PORT_B,
                program_counter_high_latch: bdm_pkg::POR_PC_HIGH_LATCH,
                interrupt_control: bdm_pkg::POR_INTERRUPT_CONTROL,
                peripheral_flags: bdm_pkg::POR_PERIPHERAL_FLAGS,
                comparator_control: bdm_pkg::POR_COMPARATOR,
                core_options: bdm_pkg::POR_CORE_OPTIONS
            };
        end else if (clk_en) begin
            r <= other_reset ? rst_val : next_r;
        end
    end

    // ------------------------------------------------------------
    // general file: no reset, contents survive every reset
    // ------------------------------------------------------------
    // no reset: clearing every cell would need a wide reset tree
    // limitation: cells read unknown until first written
    // bank 0 RAM writes
    // bank 1 RAM through the same array
    // common window shares bank 0 cells
    // 8-bit cells, depth gated by variant
    always_ff @(posedge sys_clk) begin
        if (wr && !is_sfr && ram_hit) begin
            ram[ram_idx] <= wd;
        end
    end

    // ------------------------------------------------------------
    // read port, one cycle latency
    // ------------------------------------------------------------
    // a flop output costs a cycle of latency but keeps timing clean
    // rd_data holds between reads so the core may take it late
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end else if (clk_en) begin
            rd_valid <= rd;
            if (rd) begin
                rd_data <= next_rd_data;
            end
        end
    end

    // straight from the register flops
    assign regs = r;

endmodule

// [bench/bdm_checker.sv]
`timescale 1ns/1ps
module bdm_checker (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic other_reset,
    input wire bdm_pkg::bdm_req_s req,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire bdm_pkg::bdm_regs_s regs
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    wire logic take_wr = clk_en && req.wr && !other_reset && !req.indirect;
    chk_read_valid_pulse: assert property (
        clk_en && req.rd |=> rd_valid)
        else $error("read not answered");
    chk_no_stray_valid: assert property (
        clk_en && !req.rd |=> !rd_valid)
        else $error("valid without read");
    chk_read_data_hold: assert property (
        clk_en && !req.rd |=> $stable(rd_data))
        else $error("read data moved");
    chk_frozen_state: assert property (
        !clk_en |=> $stable(regs))
        else $error("state moved while frozen");
    chk_flags_other_reset: assert property (
        clk_en && other_reset |=>
        regs.core_flags[7:5] == 3'h0 && $stable(regs.core_flags[4:0]))
        else $error("flags wrong after other reset");
    chk_kept_other_reset: assert property (
        clk_en && other_reset |=>
        $stable(regs.indirect_pointer) && $stable(regs.timer_count) &&
        regs.core_options == 8'hFF)
        else $error("other reset values wrong");
    chk_unused_bits_zero: assert property (
        regs.port_a_pins[7:5] == 3'h0 &&
        regs.program_counter_high_latch[7:5] == 3'h0 &&
        (regs.peripheral_flags & 8'hBF) == 8'h00 &&
        regs.comparator_control[5:4] == 2'h0)
        else $error("unimplemented bit set");
    chk_pointer_write: assert property (
        take_wr && req.addr == 7'h04 |=>
        regs.indirect_pointer == $past(req.wdata))
        else $error("pointer write lost");
    // bank bit picks timer or options at the same offset
    chk_bank_select: assert property (
        take_wr && req.addr == 7'h01 |=>
        ($past(regs.core_flags[5]) ? regs.core_options : regs.timer_count)
        == $past(req.wdata))
        else $error("wrong bank decoded");
    cover property (clk_en && req.rd);
    cover property (clk_en && other_reset);
    cover property (take_wr && req.addr == 7'h01 && regs.core_flags[5]);
endmodule
bind bdm_decoder bdm_checker chk_u (.sys_clk(sys_clk), .resetn(resetn),
    .clk_en(clk_en), .other_reset(other_reset), .req(req),
    .rd_data(rd_data), .rd_valid(rd_valid), .regs(regs));

// [bench/test_banked_data_memory_decoder.sv]
`timescale 1ns/1ps
module test_banked_data_memory_decoder;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic other_reset = 1'b0;
    bdm_pkg::bdm_req_s req = '0;
    logic [7:0] rd_data;
    logic rd_valid;
    logic [7:0] rd_data_80;
    bdm_pkg::bdm_regs_s regs;
    int miscompares = 0;
    int checks = 0;
    bdm_decoder dut_u (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
        .other_reset(other_reset), .req(req), .rd_data(rd_data),
        .rd_valid(rd_valid), .regs(regs));
    // smallest file: no bank 1 block and no common window
    bdm_decoder #(.VARIANT(bdm_pkg::VARIANT_80)) dut_80 (.sys_clk(sys_clk),
        .resetn(resetn), .clk_en(clk_en), .other_reset(other_reset),
        .req(req), .rd_data(rd_data_80), .rd_valid(), .regs());
    always #20 sys_clk = ~sys_clk;
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic test_done();
        if (miscompares == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // one idle cycle follows every access, so drivers never collide
    task automatic acc(input logic r, input logic i, input logic [6:0] a,
            input logic [7:0] d);
        @(negedge sys_clk);
        req = {r, ~r, i, a, d};
        @(posedge sys_clk);
        #1;
        @(negedge sys_clk);
        req = '0;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        acc(1'b0, 1'b0, a, d);
    endtask
    task automatic rd(input logic i, input logic [6:0] a,
            input logic [7:0] exp);
        acc(1'b1, i, a, 8'h00);
        check(rd_data, exp);
        check({7'h00, rd_valid}, 8'h01);
    endtask
    initial begin
        #100000;
        miscompares++;
        test_done();
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        resetn = 1'b1;
        check(regs.core_flags, 8'h18);
        check(regs.core_options, 8'hFF);
        rd(1'b0, 7'h03, 8'h18);
        wr(7'h04, 8'h3A);
        rd(1'b0, 7'h04, 8'h3A);
        wr(7'h00, 8'h55);
        rd(1'b0, 7'h3A, 8'h55);
        acc(1'b0, 1'b1, 7'h11, 8'hC3);
        rd(1'b0, 7'h3A, 8'hC3);
        wr(7'h20, 8'h85);
        wr(7'h7F, 8'hDA);
        rd(1'b0, 7'h20, 8'h85);
        check(rd_data_80, 8'h85);
        rd(1'b0, 7'h7F, 8'hDA);
        check(rd_data_80, 8'h00);
        rd(1'b0, 7'h07, 8'h00);
        wr(7'h0A, 8'hFF);
        rd(1'b0, 7'h0A, 8'h1F);
        wr(7'h0C, 8'hFF);
        check(regs.peripheral_flags, 8'h40);
        wr(7'h04, 8'h00);
        rd(1'b0, 7'h00, 8'h00);
        wr(7'h02, 8'h12);
        wr(7'h03, 8'h20);
        check({7'h00, regs.core_flags[5]}, 8'h01);
        wr(7'h01, 8'h5A);
        check(regs.core_options, 8'h5A);
        check(regs.timer_count, 8'h00);
        rd(1'b0, 7'h02, 8'h12);
        rd(1'b0, 7'h05, 8'h00);
        wr(7'h20, 8'h77);
        wr(7'h70, 8'h99);
        wr(7'h03, 8'h00);
        rd(1'b0, 7'h20, 8'h85);
        rd(1'b0, 7'h70, 8'h99);
        check(rd_data_80, 8'h00);
        rd(1'b0, 7'h01, 8'h00);
        wr(7'h04, 8'hA0);
        rd(1'b1, 7'h00, 8'h77);
        check(rd_data_80, 8'h00);
        wr(7'h01, 8'h3C);
        wr(7'h05, 8'hFF);
        wr(7'h06, 8'hA5);
        wr(7'h0B, 8'hFF);
        wr(7'h1F, 8'hFF);
        rd(1'b0, 7'h05, 8'h1F);
        rd(1'b0, 7'h06, 8'hA5);
        rd(1'b0, 7'h1F, 8'hCF);
        // frozen clock enable must drop the write
        @(negedge sys_clk);
        clk_en = 1'b0;
        wr(7'h04, 8'h11);
        clk_en = 1'b1;
        check(regs.indirect_pointer, 8'hA0);
        @(negedge sys_clk);
        other_reset = 1'b1;
        @(negedge sys_clk);
        other_reset = 1'b0;
        check(regs.indirect_pointer, 8'hA0);
        check(regs.timer_count, 8'h3C);
        check(regs.core_options, 8'hFF);
        check(regs.program_counter_high_latch, 8'h00);
        check(regs.program_counter_low, 8'h00);
        check(regs.port_a_pins, 8'h10);
        check(regs.port_b_pins, 8'hA5);
        check(regs.interrupt_control, 8'h01);
        check(regs.comparator_control, 8'h00);
        check(regs.peripheral_flags, 8'h00);
        rd(1'b0, 7'h70, 8'h99);
        @(negedge sys_clk);
        resetn = 1'b0;
        #1;
        check(regs.timer_count, 8'h00);
        check(regs.core_flags, 8'h18);
        @(negedge sys_clk);
        resetn = 1'b1;
        rd(1'b0, 7'h04, 8'h00);
        test_done();
    end
endmodule
